// >>> pqt_pkg.sv
`default_nettype none

package pqt_pkg;

  localparam int unsigned PORTS  = 3;
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned VID_W  = 12;
  localparam int unsigned PID_W  = 2;

  // Byte addresses of the per-port control registers
  localparam logic [ADDR_W-1:0] PORT1_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] PORT2_OFF = 8'h20;
  localparam logic [ADDR_W-1:0] PORT3_OFF = 8'h30;
  localparam logic [PORTS-1:0][ADDR_W-1:0] PORT_OFF = {PORT3_OFF, PORT2_OFF, PORT1_OFF};

  // Port numbers carried with a packet
  localparam logic [PID_W-1:0] PORT1_ID = 2'h1;
  localparam logic [PID_W-1:0] PORT2_ID = 2'h2;
  localparam logic [PID_W-1:0] PORT3_ID = 2'h3;

  // Field positions, identical for every port
  localparam int unsigned BIT_STORM    = 7;
  localparam int unsigned BIT_DSCP     = 6;
  localparam int unsigned BIT_VPRIO    = 5;
  localparam int unsigned BIT_PORT_HI  = 4;
  localparam int unsigned BIT_CEILING  = 3;
  localparam int unsigned BIT_TAG_ADD  = 2;
  localparam int unsigned BIT_TAG_STRP = 1;
  localparam int unsigned BIT_DUAL_Q   = 0;

  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [CTRL_W-1:0] RD_UNMAPPED = 8'h00;

  // Strap handling: two synchroniser stages, then one load edge on settled data
  localparam int unsigned SYNC_STAGES       = 2;
  localparam int unsigned STRAP_LOAD_CYCLES = SYNC_STAGES + 1;
  localparam int unsigned STRAP_CNT_W       = 2;
  localparam logic [STRAP_CNT_W-1:0] STRAP_CNT_INIT = STRAP_CNT_W'(STRAP_LOAD_CYCLES);
  localparam logic [STRAP_CNT_W-1:0] STRAP_CNT_DONE = 2'h0;
  localparam logic [STRAP_CNT_W-1:0] STRAP_CNT_STEP = 2'h1;

  function automatic logic [CTRL_W-1:0] pqt_strap_word(input logic vprio,
                                                       input logic port_hi,
                                                       input logic tag_add,
                                                       input logic tag_strip,
                                                       input logic dual_q);
    logic [CTRL_W-1:0] w;
    w = CTRL_RST;
    w[BIT_VPRIO]    = vprio;
    w[BIT_PORT_HI]  = port_hi;
    w[BIT_TAG_ADD]  = tag_add;
    w[BIT_TAG_STRP] = tag_strip;
    w[BIT_DUAL_Q]   = dual_q;
    return w;
  endfunction

endpackage

`default_nettype wire

// >>> pqt_cfg_if.sv
`default_nettype none

interface pqt_cfg_if;
  logic [pqt_pkg::CTRL_W-1:0] ctrl;
  modport src (output ctrl);
  modport dst (input ctrl);
endinterface

`default_nettype wire

// >>> pqt_port_reg.sv
`default_nettype none

module pqt_port_reg (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       strap_load_i,
  input  wire logic [pqt_pkg::CTRL_W-1:0] strap_i,
  input  wire logic                       wr_i,
  input  wire logic [pqt_pkg::CTRL_W-1:0] wdata_i,
  pqt_cfg_if.src                          cfg
);
  import pqt_pkg::*;

  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;

  // Strap loading owns the register until it ends; writes then are dropped
  assign ctrl_nxt = strap_load_i ? strap_i : (wr_i ? wdata_i : ctrl_r);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign cfg.ctrl = ctrl_r;

endmodule // pqt_port_reg

`default_nettype wire

// >>> pqt_pkt_policy.sv
`default_nettype none

module pqt_pkt_policy (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      pkt_valid_i,
  input  wire logic                      pkt_tagged_i,
  input  wire logic                      pkt_broadcast_i,
  input  wire logic [pqt_pkg::PRIO_W-1:0] pkt_user_prio_i,
  input  wire logic                      pkt_dscp_hit_i,
  input  wire logic                      pkt_dscp_high_i,
  input  wire logic                      pkt_vprio_high_i,
  input  wire logic [pqt_pkg::PRIO_W-1:0] def_prio_i,
  input  wire logic [pqt_pkg::VID_W-1:0]  ing_vid_i,
  pqt_cfg_if.dst                         ing_cfg,
  pqt_cfg_if.dst                         egr_cfg,
  output logic                           res_valid_o,
  output logic                           storm_check_o,
  output logic                           prio_high_o,
  output logic [pqt_pkg::PRIO_W-1:0]     user_prio_o,
  output logic                           tag_add_o,
  output logic                           tag_strip_o,
  output logic [pqt_pkg::VID_W-1:0]      tag_vid_o,
  output logic                           queue_high_o
);
  import pqt_pkg::*;

  wire               dscp_used  = ing_cfg.ctrl[BIT_DSCP] & pkt_dscp_hit_i;
  wire               vprio_used = ing_cfg.ctrl[BIT_VPRIO] & pkt_tagged_i;
  wire               class_hit  = dscp_used | vprio_used;
  // Either classifier's high result wins over the port default
  wire               class_high = (dscp_used & pkt_dscp_high_i) |
                                  (vprio_used & pkt_vprio_high_i);
  wire               high       = class_hit ? class_high : ing_cfg.ctrl[BIT_PORT_HI];
  wire               ceil_hit   = ing_cfg.ctrl[BIT_CEILING] & pkt_tagged_i &
                                  (pkt_user_prio_i > def_prio_i);
  wire [PRIO_W-1:0]  prio_out   = ceil_hit ? def_prio_i : pkt_user_prio_i;
  wire               add_tag    = egr_cfg.ctrl[BIT_TAG_ADD] & ~pkt_tagged_i;
  wire               strip_tag  = egr_cfg.ctrl[BIT_TAG_STRP] & pkt_tagged_i;
  // Single queue ignores the class even though it was computed
  wire               q_high     = egr_cfg.ctrl[BIT_DUAL_Q] & high;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_valid_o   <= 1'b0;
      storm_check_o <= 1'b0;
      prio_high_o   <= 1'b0;
      user_prio_o   <= '0;
      tag_add_o     <= 1'b0;
      tag_strip_o   <= 1'b0;
      tag_vid_o     <= '0;
      queue_high_o  <= 1'b0;
    end else begin
      res_valid_o <= pkt_valid_i;
      if (pkt_valid_i) begin
        storm_check_o <= ing_cfg.ctrl[BIT_STORM] & pkt_broadcast_i;
        prio_high_o   <= high;
        user_prio_o   <= prio_out;
        tag_add_o     <= add_tag;
        tag_strip_o   <= strip_tag;
        tag_vid_o     <= ing_vid_i;
        queue_high_o  <= q_high;
      end
    end
  end

endmodule // pqt_pkt_policy

`default_nettype wire

// >>> port_qos_tag_control.sv
`default_nettype none

module port_qos_tag_control (
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  // Register access
  input  wire logic [pqt_pkg::ADDR_W-1:0]         reg_addr_i,
  input  wire logic                               reg_wr_i,
  input  wire logic [pqt_pkg::CTRL_W-1:0]         reg_wdata_i,
  input  wire logic                               reg_rd_i,
  output logic [pqt_pkg::CTRL_W-1:0]              reg_rdata_o,
  output logic                                    reg_rvalid_o,
  output logic                                    reg_busy_o,
  // Strap pins
  input  wire logic                               first_port_vlan_prio_class_strap,
  input  wire logic                               second_port_vlan_prio_class_strap,
  input  wire logic                               third_port_vlan_prio_class_strap,
  input  wire logic                               first_port_default_high_strap,
  input  wire logic                               second_port_default_high_strap,
  input  wire logic                               third_port_default_high_strap,
  input  wire logic                               first_port_tag_add_strap,
  input  wire logic                               second_port_tag_add_strap,
  input  wire logic                               third_port_tag_add_strap,
  input  wire logic                               first_port_tag_strip_strap,
  input  wire logic                               second_port_tag_strip_strap,
  input  wire logic                               third_port_tag_strip_strap,
  input  wire logic                               first_port_dual_queue_strap,
  input  wire logic                               second_port_dual_queue_strap,
  input  wire logic                               third_port_dual_queue_strap,
  // Per-port default tag fields, held outside this block
  input  wire logic [pqt_pkg::PORTS*pqt_pkg::PRIO_W-1:0] def_user_prio_i,
  input  wire logic [pqt_pkg::PORTS*pqt_pkg::VID_W-1:0]  port_default_vlan_id,
  // Packet decision request
  input  wire logic                               pkt_valid_i,
  input  wire logic [pqt_pkg::PID_W-1:0]          pkt_ingress_i,
  input  wire logic [pqt_pkg::PID_W-1:0]          pkt_egress_i,
  input  wire logic                               pkt_tagged_i,
  input  wire logic                               pkt_broadcast_i,
  input  wire logic [pqt_pkg::PRIO_W-1:0]         pkt_user_prio_i,
  input  wire logic                               pkt_dscp_hit_i,
  input  wire logic                               pkt_dscp_high_i,
  input  wire logic                               pkt_vprio_high_i,
  // Packet decision result
  output logic                                    res_valid_o,
  output logic                                    storm_check_o,
  output logic                                    prio_high_o,
  output logic [pqt_pkg::PRIO_W-1:0]              user_prio_o,
  output logic                                    tag_add_o,
  output logic                                    tag_strip_o,
  output logic [pqt_pkg::VID_W-1:0]               tag_vid_o,
  output logic                                    queue_high_o
);
  import pqt_pkg::*;

  // Strap synchroniser: meta stage feeds only the settled stage
  logic [PORTS-1:0][CTRL_W-1:0] strap_raw;
  logic [PORTS-1:0][CTRL_W-1:0] strap_meta_r;
  logic [PORTS-1:0][CTRL_W-1:0] strap_sync_r;
  logic [STRAP_CNT_W-1:0]       strap_cnt_r;
  logic [STRAP_CNT_W-1:0]       strap_cnt_nxt;
  wire                          strap_load = (strap_cnt_r != STRAP_CNT_DONE);

  // Pins gathered per field; index 0 is the first port
  wire [PORTS-1:0] vp_pins;
  wire [PORTS-1:0] hi_pins;
  wire [PORTS-1:0] ta_pins;
  wire [PORTS-1:0] ts_pins;
  wire [PORTS-1:0] dq_pins;

  assign vp_pins[0] = first_port_vlan_prio_class_strap;
  assign vp_pins[1] = second_port_vlan_prio_class_strap;
  assign vp_pins[2] = third_port_vlan_prio_class_strap;

  assign hi_pins[0] = first_port_default_high_strap;
  assign hi_pins[1] = second_port_default_high_strap;
  assign hi_pins[2] = third_port_default_high_strap;

  assign ta_pins[0] = first_port_tag_add_strap;
  assign ta_pins[1] = second_port_tag_add_strap;
  assign ta_pins[2] = third_port_tag_add_strap;

  assign ts_pins[0] = first_port_tag_strip_strap;
  assign ts_pins[1] = second_port_tag_strip_strap;
  assign ts_pins[2] = third_port_tag_strip_strap;

  assign dq_pins[0] = first_port_dual_queue_strap;
  assign dq_pins[1] = second_port_dual_queue_strap;
  assign dq_pins[2] = third_port_dual_queue_strap;

  // Count down once per edge until the load window closes
  assign strap_cnt_nxt = strap_load ?
                         (strap_cnt_r - STRAP_CNT_STEP) :
                         strap_cnt_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_meta_r <= '0;
    end else begin
      strap_meta_r <= strap_raw;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_sync_r <= '0;
    end else begin
      strap_sync_r <= strap_meta_r;
    end
  end

  // The last load edge is the first that sees settled strap levels
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_cnt_r <= STRAP_CNT_INIT;
    end else begin
      strap_cnt_r <= strap_cnt_nxt;
    end
  end

  // Software sees the bank as busy while straps are still being caught
  assign reg_busy_o = strap_load;

  pqt_cfg_if port_cfg [PORTS] ();
  logic [PORTS-1:0][CTRL_W-1:0] ctrl_q;
  logic [PORTS-1:0]             addr_hit;
  wire  [PORTS-1:0]             port_wr;

  genvar i;
  generate
    for (i = 0; i < PORTS; i++) begin : g_port
      assign strap_raw[i] = pqt_strap_word(vp_pins[i],
                                           hi_pins[i],
                                           ta_pins[i],
                                           ts_pins[i],
                                           dq_pins[i]);

      assign addr_hit[i]  = (reg_addr_i == PORT_OFF[i]);
      assign port_wr[i]   = reg_wr_i & addr_hit[i];

      assign ctrl_q[i]    = port_cfg[i].ctrl;

      // One register module per port keeps the layout identical
      pqt_port_reg u_reg (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .strap_load_i (strap_load),
        .strap_i      (strap_sync_r[i]),
        .wr_i         (port_wr[i]),
        .wdata_i      (reg_wdata_i),
        .cfg          (port_cfg[i])
      );
    end
  endgenerate

  // Read path; unmapped addresses return zero
  wire [CTRL_W-1:0] rd_sel = addr_hit[0] ? ctrl_q[0] :
                             addr_hit[1] ? ctrl_q[1] :
                             addr_hit[2] ? ctrl_q[2] :
                                           RD_UNMAPPED;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // Data holds between reads, so a late sampler still sees the last answer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= RD_UNMAPPED;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_sel;
    end
  end

  // Port selection for the packet; an illegal port number sees all-zero control
  wire ing1 = (pkt_ingress_i == PORT1_ID);
  wire ing2 = (pkt_ingress_i == PORT2_ID);
  wire ing3 = (pkt_ingress_i == PORT3_ID);

  wire egr1 = (pkt_egress_i == PORT1_ID);
  wire egr2 = (pkt_egress_i == PORT2_ID);
  wire egr3 = (pkt_egress_i == PORT3_ID);

  // Default tag fields of each ingress port
  wire [PRIO_W-1:0] def_prio1 = def_user_prio_i[0*PRIO_W +: PRIO_W];
  wire [PRIO_W-1:0] def_prio2 = def_user_prio_i[1*PRIO_W +: PRIO_W];
  wire [PRIO_W-1:0] def_prio3 = def_user_prio_i[2*PRIO_W +: PRIO_W];
  wire [VID_W-1:0]  def_vid1  = port_default_vlan_id[0*VID_W +: VID_W];
  wire [VID_W-1:0]  def_vid2  = port_default_vlan_id[1*VID_W +: VID_W];
  wire [VID_W-1:0]  def_vid3  = port_default_vlan_id[2*VID_W +: VID_W];

  wire [PRIO_W-1:0] def_prio = ing1 ? def_prio1 :
                               ing2 ? def_prio2 :
                               ing3 ? def_prio3 :
                                      '0;
  wire [VID_W-1:0]  ing_vid  = ing1 ? def_vid1 :
                               ing2 ? def_vid2 :
                               ing3 ? def_vid3 :
                                      '0;

  pqt_cfg_if ing_cfg ();
  pqt_cfg_if egr_cfg ();

  // Ingress control decides class and ceiling; egress control decides tag and queue
  assign ing_cfg.ctrl = ing1 ? ctrl_q[0] :
                        ing2 ? ctrl_q[1] :
                        ing3 ? ctrl_q[2] :
                               CTRL_RST;

  assign egr_cfg.ctrl = egr1 ? ctrl_q[0] :
                        egr2 ? ctrl_q[1] :
                        egr3 ? ctrl_q[2] :
                               CTRL_RST;

  pqt_pkt_policy u_policy (
    .clk_i            (clk_i),
    .rst_i            (rst_i),

    // Packet fields as offered
    .pkt_valid_i      (pkt_valid_i),
    .pkt_tagged_i     (pkt_tagged_i),
    .pkt_broadcast_i  (pkt_broadcast_i),
    .pkt_user_prio_i  (pkt_user_prio_i),
    .pkt_dscp_hit_i   (pkt_dscp_hit_i),
    .pkt_dscp_high_i  (pkt_dscp_high_i),
    .pkt_vprio_high_i (pkt_vprio_high_i),

    // Context of the ports involved
    .def_prio_i       (def_prio),
    .ing_vid_i        (ing_vid),
    .ing_cfg          (ing_cfg),
    .egr_cfg          (egr_cfg),

    // Decision, registered inside
    .res_valid_o      (res_valid_o),
    .storm_check_o    (storm_check_o),
    .prio_high_o      (prio_high_o),
    .user_prio_o      (user_prio_o),
    .tag_add_o        (tag_add_o),
    .tag_strip_o      (tag_strip_o),
    .tag_vid_o        (tag_vid_o),
    .queue_high_o     (queue_high_o)
  );

endmodule // port_qos_tag_control

`default_nettype wire

// >>> pqt_gap_note_unused.sv
`default_nettype none
`default_nettype wire

// >>> pqt_asserts.sv
`default_nettype none

module pqt_asserts (
  input wire logic                                  clk_i,
  input wire logic                                  rst_i,
  input wire logic                                  reg_rd_i,
  input wire logic                                  reg_rvalid_o,
  input wire logic                                  pkt_valid_i,
  input wire logic [pqt_pkg::PID_W-1:0]             pkt_ingress_i,
  input wire logic                                  pkt_tagged_i,
  input wire logic                                  pkt_broadcast_i,
  input wire logic [pqt_pkg::PRIO_W-1:0]            pkt_user_prio_i,
  input wire logic [pqt_pkg::PORTS*pqt_pkg::VID_W-1:0] port_default_vlan_id,
  input wire logic                                  res_valid_o,
  input wire logic                                  storm_check_o,
  input wire logic                                  prio_high_o,
  input wire logic [pqt_pkg::PRIO_W-1:0]            user_prio_o,
  input wire logic                                  tag_add_o,
  input wire logic                                  tag_strip_o,
  input wire logic [pqt_pkg::VID_W-1:0]             tag_vid_o,
  input wire logic                                  queue_high_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pqt_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_rvalid_after_rd: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no read answer");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray rvalid");
  a_res_one_cycle: assert property (pkt_valid_i |=> res_valid_o) else $error("no result");
  a_res_cause: assert property (res_valid_o |-> $past(pkt_valid_i)) else $error("stray result");
  a_storm_bcast: assert property (res_valid_o && storm_check_o |-> $past(pkt_broadcast_i))
    else $error("storm check on non-broadcast");
  a_ceiling_cap: assert property (res_valid_o |-> user_prio_o <= $past(pkt_user_prio_i))
    else $error("priority raised");
  a_untag_prio: assert property (res_valid_o && !$past(pkt_tagged_i)
    |-> user_prio_o == $past(pkt_user_prio_i)) else $error("untagged priority changed");
  a_add_untagged: assert property (res_valid_o && tag_add_o |-> !$past(pkt_tagged_i))
    else $error("tag added to tagged packet");
  a_strip_tagged: assert property (res_valid_o && tag_strip_o |-> $past(pkt_tagged_i))
    else $error("strip on untagged packet");
  a_queue_class: assert property (res_valid_o && queue_high_o |-> prio_high_o)
    else $error("high queue for low class");
  a_vid_port1: assert property (res_valid_o && $past(pkt_ingress_i) == PORT1_ID
    |-> tag_vid_o == $past(port_default_vlan_id[VID_W-1:0])) else $error("wrong vid");
  a_hold_result: assert property (!pkt_valid_i |=> $stable({storm_check_o, prio_high_o,
    user_prio_o, tag_vid_o})) else $error("result changed without request");
endmodule // pqt_asserts

bind port_qos_tag_control pqt_asserts u_pqt_asserts (.clk_i, .rst_i, .reg_rd_i, .reg_rvalid_o,
  .pkt_valid_i, .pkt_ingress_i, .pkt_tagged_i, .pkt_broadcast_i, .pkt_user_prio_i,
  .port_default_vlan_id, .res_valid_o, .storm_check_o, .prio_high_o, .user_prio_o, .tag_add_o,
  .tag_strip_o, .tag_vid_o, .queue_high_o);

`default_nettype wire

// >>> port_qos_tag_control_tb_top.sv
`default_nettype none

module port_qos_tag_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pqt_pkg::*;
  logic        clk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, reg_busy_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [2:0]  s_vp, s_hi, s_ta, s_ts, s_dq;
  logic        pkt_valid_i, pkt_tagged_i, pkt_broadcast_i, dhit, dhigh, vhigh;
  logic [1:0]  pkt_ingress_i, pkt_egress_i;
  logic [2:0]  pkt_user_prio_i, user_prio_o;
  logic        res_valid_o, storm_check_o, prio_high_o, tag_add_o, tag_strip_o, queue_high_o;
  logic [11:0] tag_vid_o;
  logic [7:0]  sh [4];
  logic [2:0]  dp [4] = '{3'h0, 3'h4, 3'h2, 3'h5};
  logic [11:0] vd [4] = '{12'h000, 12'h111, 12'h222, 12'h333};
  localparam logic [4:0][7:0] CSET = {8'hFF, 8'h00, 8'h7A, 8'h85, 8'h59};
  int bad_count = 0;
  int num_checks = 0;

  port_qos_tag_control u_port_qos_tag_control (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .reg_busy_o,
    .first_port_vlan_prio_class_strap(s_vp[0]), .second_port_vlan_prio_class_strap(s_vp[1]),
    .third_port_vlan_prio_class_strap(s_vp[2]), .first_port_default_high_strap(s_hi[0]),
    .second_port_default_high_strap(s_hi[1]), .third_port_default_high_strap(s_hi[2]),
    .first_port_tag_add_strap(s_ta[0]), .second_port_tag_add_strap(s_ta[1]),
    .third_port_tag_add_strap(s_ta[2]), .first_port_tag_strip_strap(s_ts[0]),
    .second_port_tag_strip_strap(s_ts[1]), .third_port_tag_strip_strap(s_ts[2]),
    .first_port_dual_queue_strap(s_dq[0]), .second_port_dual_queue_strap(s_dq[1]),
    .third_port_dual_queue_strap(s_dq[2]), .def_user_prio_i({dp[3], dp[2], dp[1]}),
    .port_default_vlan_id({vd[3], vd[2], vd[1]}), .pkt_valid_i, .pkt_ingress_i,
    .pkt_egress_i, .pkt_tagged_i, .pkt_broadcast_i, .pkt_user_prio_i,
    .pkt_dscp_hit_i(dhit), .pkt_dscp_high_i(dhigh), .pkt_vprio_high_i(vhigh), .res_valid_o,
    .storm_check_o, .prio_high_o, .user_prio_o, .tag_add_o, .tag_strip_o, .tag_vid_o,
    .queue_high_o);

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t register got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_res(input logic [20:0] got, input logic [20:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t result got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    for (int k = 0; k < 3; k++) if (a == PORT_OFF[k]) sh[k+1] = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    // Idle cycle, so a following call never lowers and raises a strobe at once
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk_reg({reg_rvalid_o, reg_rdata_o}, {1'b1, e});
    @(negedge clk_i);
  endtask

  // A write lands in the busy window after release and must be lost
  task automatic do_reset(input logic p);
    rst_i = 1'b1;
    {s_vp, s_hi, s_ta, s_ts, s_dq} = {3'b101, 3'b110, 3'b101, 3'b110, 3'b101} ^ {15{p}};
    repeat (12) @(negedge clk_i);
    chk_reg({8'h00, reg_busy_o}, 9'h001);
    rst_i = 1'b0;
    wr(PORT1_OFF, 8'hFF);
    chk_reg({8'h00, reg_busy_o}, 9'h001);
    for (int n = 0; n < 8 && reg_busy_o !== 1'b0; n++) @(negedge clk_i);
    for (int k = 1; k <= 3; k++) begin
      sh[k] = {2'b00, s_vp[k-1], s_hi[k-1], 1'b0, s_ta[k-1], s_ts[k-1], s_dq[k-1]};
      rd(PORT_OFF[k-1], sh[k]);
    end
  endtask

  task automatic reg_sweep();
    for (int v = 0; v < 3; v++) begin
      for (int k = 1; k <= 3; k++) begin
        wr(PORT_OFF[k-1], CSET[v] ^ 8'(k));
        rd(PORT_OFF[k-1], sh[k]);
      end
    end
    wr(8'h40, 8'hFF);
    for (int k = 1; k <= 3; k++) rd(PORT_OFF[k-1], sh[k]);
    rd(8'h40, RD_UNMAPPED);
    rd(8'h11, RD_UNMAPPED);
  endtask

  function automatic logic [20:0] model(input logic [5:0] v, input logic [2:0] up,
                                       input logic h, input logic g, input logic b);
    logic [7:0] ci;
    logic [7:0] ce;
    logic du;
    logic vu;
    logic hi;
    ci = sh[v[1:0]];
    ce = sh[v[3:2]];
    du = ci[6] & h;
    vu = ci[5] & v[4];
    hi = (du | vu) ? ((du & g) | (vu & b)) : ci[4];
    if (ci[3] && v[4] && up > dp[v[1:0]]) up = dp[v[1:0]];
    return {1'b1, ci[7] & v[5], hi, up, ce[2] & !v[4], ce[1] & v[4], vd[v[1:0]], ce[0] & hi};
  endfunction

  // Packets go back to back; each result is judged while the next is offered
  task automatic pkt_sweep();
    logic [20:0] e;
    logic [5:0]  v;
    for (int c = 0; c < 5; c++) begin
      for (int k = 1; k <= 3; k++) wr(PORT_OFF[k-1], CSET[(c + k) % 5]);
      for (int i = 0; i <= 64; i++) begin
        if (i > 0) chk_res({res_valid_o, storm_check_o, prio_high_o, user_prio_o, tag_add_o,
          tag_strip_o, tag_vid_o, queue_high_o}, e);
        v = 6'(i);
        pkt_valid_i = (i < 64);
        {pkt_broadcast_i, pkt_tagged_i, pkt_egress_i, pkt_ingress_i} = v;
        pkt_user_prio_i = 3'(i * 3 + c);
        dhit = v[0] ^ v[2];
        dhigh = v[3] ^ v[4];
        vhigh = v[1] ^ v[5] ^ c[0];
        e = model(v, pkt_user_prio_i, dhit, dhigh, vhigh);
        @(negedge clk_i);
      end
    end
  endtask

  initial begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {pkt_valid_i, pkt_tagged_i, pkt_broadcast_i, dhit, dhigh, vhigh} = '0;
    {pkt_ingress_i, pkt_egress_i, pkt_user_prio_i} = '0;
    sh[0] = 8'h00;
    do_reset(1'b0);
    reg_sweep();
    pkt_sweep();
    do_reset(1'b1);
    pkt_sweep();
    stop_test();
  end

  initial begin
    repeat (6000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end
endmodule // port_qos_tag_control_tb_top

`default_nettype wire
